// ### dsau_regs.vh
// constants shared by the data-space access unit files
`ifndef DSAU_REGS_VH
`define DSAU_REGS_VH

// stack pointer value after reset
`define DSAU_SP_RST       16'h0800
// stack addresses below this bound are an underflow
`define DSAU_SP_FLOOR     16'h0800
// all-zero answer for invalid accesses
`define DSAU_ZERO_WORD    16'h0000
`define DSAU_ZERO_BYTE    8'h00
// pointer steps for post-increment and stack moves
`define DSAU_BYTE_STEP    16'h0001
`define DSAU_WORD_STEP    16'h0002
// width of the near direct address field
`define DSAU_NEAR_W       13
// kinds of word pushed onto the stack
`define DSAU_PUSH_DATA    2'h0
`define DSAU_PUSH_CALL    2'h1
`define DSAU_PUSH_EXC     2'h2
// default map of the implemented data memory and its y part
`define DSAU_MEM_LO       16'h0800
`define DSAU_MEM_HI       16'h08ff
`define DSAU_Y_LO         16'h0880
`define DSAU_Y_HI         16'h08ff
// default count of reversed address bits above bit 0
`define DSAU_BR_BITS      8

`endif

// ### dsau_stack.v
// software stack pointer, stack limit and stack error detection
`timescale 1ns/10ps
`default_nettype none
`include "dsau_regs.vh"

module dsau_stack (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // stack operations from the core
  input  wire        push_in,
  input  wire        pop_in,
  input  wire [1:0]  push_src_in,
  input  wire [15:0] push_data_in,
  input  wire [7:0]  status_low_byte_in,
  // pointer and limit writes
  input  wire        sp_wr_in,
  input  wire [15:0] sp_wdata_in,
  input  wire        limit_wr_in,
  input  wire [15:0] limit_wdata_in,
  // effective address and data for the x bus
  output reg  [15:0] stk_ea_out,
  output reg  [15:0] stk_wdata_out,
  output wire        stk_err_out,
  output reg  [15:0] stack_pointer_out
);

  reg  [15:0] stack_limit_r;
  reg         limit_loaded_r;
  wire [15:0] sp_dec;

  assign sp_dec = stack_pointer_out - `DSAU_WORD_STEP;

  // push uses the free word, pop the word below it
  always @* begin
    stk_ea_out = pop_in ? sp_dec : stack_pointer_out;
  end

  always @* begin
    case (push_src_in)
      `DSAU_PUSH_CALL: stk_wdata_out = {`DSAU_ZERO_BYTE, push_data_in[7:0]};
      `DSAU_PUSH_EXC:  stk_wdata_out = {status_low_byte_in, push_data_in[7:0]};
      default:         stk_wdata_out = push_data_in;
    endcase
  end

  // equal to the limit is still legal; one word beyond traps
  assign stk_err_out = (push_in | pop_in) &
                       ((limit_loaded_r & (stk_ea_out > stack_limit_r)) |
                        (stk_ea_out < `DSAU_SP_FLOOR));

  always @(posedge mclk_in) begin
    if (rst_in) begin
      stack_pointer_out <= `DSAU_SP_RST;
    end else if (sp_wr_in) begin
      stack_pointer_out <= {sp_wdata_in[15:1], 1'b0};
    end else if (push_in) begin
      stack_pointer_out <= stack_pointer_out + `DSAU_WORD_STEP;
    end else if (pop_in) begin
      stack_pointer_out <= sp_dec;
    end
  end

  // the limit itself is not reset; checks wait until it is written
  always @(posedge mclk_in) begin
    if (limit_wr_in) begin
      stack_limit_r <= {limit_wdata_in[15:1], 1'b0};
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      limit_loaded_r <= 1'b0;
    end else if (limit_wr_in) begin
      limit_loaded_r <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### dsau_top.v
// data-space access unit: x/y buses, alignment, invalid access and stack checks
// Behaviour
// - all data writes leave over x write bus
// - bit reversal only on x writes
// - mac reads x and y pointers concurrently
// - y bus never writes
// - accumulator write-back may hit any address
// - unimplemented address reads return zero
// - mac cross-space pointer reads return zero
// - effective addresses are 16-bit byte addresses
// - byte read selects byte onto low lane
// - byte write strobes only its lane
// - y path fetches words only
// - post-increment steps one byte or two
// - odd word access traps, write suppressed
// - byte load keeps register high byte
// - near field reaches low 8 kbyte directly
// - stack grows upward, post-inc push, pre-dec pop
// - call push clears upper byte
// - exception push carries status low byte
// - stack limit unreset, bit zero reads zero
// - push beyond stack limit traps
// - stack address below floor traps
`timescale 1ns/10ps
`default_nettype none
`include "dsau_regs.vh"

module dsau_top #(
  parameter [15:0] MEM_LO  = `DSAU_MEM_LO,
  parameter [15:0] MEM_HI  = `DSAU_MEM_HI,
  parameter [15:0] Y_LO    = `DSAU_Y_LO,
  parameter [15:0] Y_HI    = `DSAU_Y_HI,
  parameter        BR_BITS = `DSAU_BR_BITS
) (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // x access request from the core
  input  wire        xreq_valid_in,
  input  wire        xreq_write_in,
  input  wire        xreq_byte_in,
  input  wire        xreq_mac_in,
  input  wire        xreq_bitrev_in,
  input  wire        xreq_near_in,
  input  wire        xreq_postinc_in,
  input  wire [15:0] xreq_ea_in,
  input  wire [12:0] xreq_near_addr_in,
  input  wire [15:0] xreq_wdata_in,
  output wire        xreq_ready_out,
  // x read answer to the core
  input  wire [15:0] wreg_old_in,
  output reg  [15:0] x_rdata_out,
  output reg  [15:0] wreg_merged_out,
  output reg         x_rvalid_out,
  // post-increment pointer answer
  output reg  [15:0] ptr_next_out,
  output reg         ptr_next_valid_out,
  // y prefetch request and answer
  input  wire        yreq_valid_in,
  input  wire [15:0] yreq_ea_in,
  output reg  [15:0] y_rdata_out,
  output reg         y_rvalid_out,
  // stack operations
  input  wire        stk_push_in,
  input  wire        stk_pop_in,
  input  wire [1:0]  stk_push_src_in,
  input  wire [15:0] stk_push_data_in,
  input  wire [7:0]  status_low_byte_in,
  input  wire        sp_wr_in,
  input  wire [15:0] sp_wdata_in,
  input  wire        limit_wr_in,
  input  wire [15:0] limit_wdata_in,
  output wire [15:0] stack_pointer_out,
  // trap requests to the exception logic
  output reg         addr_err_trap_out,
  output reg         stack_err_trap_out,
  // x data memory port
  output reg  [14:0] xmem_addr_out,
  output reg         xmem_rd_out,
  output reg         xmem_we_lo_out,
  output reg         xmem_we_hi_out,
  output reg  [15:0] xmem_wdata_out,
  input  wire [15:0] xmem_rdata_in,
  // y data memory port, read only
  output reg  [14:0] ymem_addr_out,
  output reg         ymem_rd_out,
  input  wire [15:0] ymem_rdata_in
);

  // true when an address lies in [lo, hi]
  function in_range;
    input [15:0] ea;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (ea >= lo) && (ea <= hi);
    end
  endfunction

  // reverse the word-address bits above bit 0
  function [15:0] bit_rev;
    input [15:0] ea;
    integer i;
    begin
      bit_rev = ea;
      for (i = 0; i < BR_BITS; i = i + 1) begin
        bit_rev[i + 1] = ea[BR_BITS - i];
      end
    end
  endfunction

  // strobe of one byte lane: words take both lanes, bytes only their own
  function lane_we;
    input wr;
    input is_byte;
    input odd;
    input hi_lane;
    begin
      lane_we = wr & (~is_byte | (odd == hi_lane));
    end
  endfunction

  wire [15:0] stk_ea;
  wire [15:0] stk_wdata;
  wire        stk_err;

  wire        stk_op;
  wire        x_go;
  wire [15:0] x_ea_raw;
  wire [15:0] x_ea;
  wire [15:0] acc_ea;
  wire        acc_wr;
  wire        acc_rd;
  wire        acc_byte;
  wire        acc_mac;
  wire        misalign;
  wire        impl;
  wire        zero_x;
  wire        wr_ok;
  wire [15:0] acc_wdata;
  wire        y_misalign;
  wire        y_zero;

  // x read pipeline: address stage, memory stage
  reg         x_rd_s1_r;
  reg         x_byte_s1_r;
  reg         x_sel_s1_r;
  reg         x_zero_s1_r;
  reg         x_rd_s2_r;
  reg         x_byte_s2_r;
  reg         x_sel_s2_r;
  reg         x_zero_s2_r;
  reg         y_rd_s1_r;
  reg         y_zero_s1_r;
  reg         y_rd_s2_r;
  reg         y_zero_s2_r;
  reg  [7:0]  x_byte_nxt;
  reg  [15:0] x_word_nxt;

  dsau_stack u_stack (
    .mclk_in            (mclk_in),
    .rst_in             (rst_in),
    .push_in            (stk_push_in),
    .pop_in             (stk_pop_in),
    .push_src_in        (stk_push_src_in),
    .push_data_in       (stk_push_data_in),
    .status_low_byte_in (status_low_byte_in),
    .sp_wr_in           (sp_wr_in),
    .sp_wdata_in        (sp_wdata_in),
    .limit_wr_in        (limit_wr_in),
    .limit_wdata_in     (limit_wdata_in),
    .stk_ea_out         (stk_ea),
    .stk_wdata_out      (stk_wdata),
    .stk_err_out        (stk_err),
    .stack_pointer_out  (stack_pointer_out)
  );

  // a stack operation owns the x bus for its cycle
  assign stk_op         = stk_push_in | stk_pop_in;
  assign xreq_ready_out = ~stk_op;
  assign x_go           = xreq_valid_in & ~stk_op;

  // near direct field is zero-extended into the low region
  assign x_ea_raw = xreq_near_in ?
                    {3'h0, xreq_near_addr_in} : xreq_ea_in;
  assign x_ea     = (xreq_write_in & xreq_bitrev_in) ?
                    bit_rev(x_ea_raw) : x_ea_raw;

  assign acc_ea   = stk_op ? stk_ea : x_ea;
  assign acc_wr   = stk_push_in | (x_go & xreq_write_in);
  assign acc_rd   = stk_pop_in | (x_go & ~xreq_write_in);
  assign acc_byte = x_go & xreq_byte_in;
  // write-back under mac ignores the x/y split
  assign acc_mac  = x_go & xreq_mac_in & ~xreq_write_in;

  assign misalign = (acc_wr | acc_rd) & ~acc_byte & acc_ea[0];
  assign impl     = in_range(acc_ea, MEM_LO, MEM_HI);
  assign zero_x   = ~impl |
                    (acc_mac & in_range(acc_ea, Y_LO, Y_HI));
  assign wr_ok    = acc_wr & ~misalign & impl;

  assign acc_wdata = stk_push_in ? stk_wdata :
                     acc_byte ? {xreq_wdata_in[7:0], xreq_wdata_in[7:0]} :
                     xreq_wdata_in;

  // y pointers outside y space, or outside memory, read as zero
  assign y_misalign = yreq_valid_in & yreq_ea_in[0];
  assign y_zero     = ~in_range(yreq_ea_in, Y_LO, Y_HI) |
                      ~in_range(yreq_ea_in, MEM_LO, MEM_HI);

  // x memory port, one cycle per access
  always @(posedge mclk_in) begin
    if (rst_in) begin
      xmem_addr_out  <= 15'h0000;
      xmem_rd_out    <= 1'b0;
      xmem_we_lo_out <= 1'b0;
      xmem_we_hi_out <= 1'b0;
      xmem_wdata_out <= 16'h0000;
    end else begin
      xmem_addr_out  <= acc_ea[15:1];
      xmem_rd_out    <= acc_rd & impl;
      xmem_we_lo_out <= lane_we(wr_ok, acc_byte, acc_ea[0], 1'b0);
      xmem_we_hi_out <= lane_we(wr_ok, acc_byte, acc_ea[0], 1'b1);
      xmem_wdata_out <= acc_wdata;
    end
  end

  // y memory port, concurrent with x during mac prefetch
  always @(posedge mclk_in) begin
    if (rst_in) begin
      ymem_addr_out <= 15'h0000;
      ymem_rd_out   <= 1'b0;
    end else begin
      ymem_addr_out <= yreq_ea_in[15:1];
      ymem_rd_out   <= yreq_valid_in & ~y_zero;
    end
  end

  // read tracking through the memory stage
  always @(posedge mclk_in) begin
    if (rst_in) begin
      x_rd_s1_r   <= 1'b0;
      x_byte_s1_r <= 1'b0;
      x_sel_s1_r  <= 1'b0;
      x_zero_s1_r <= 1'b0;
      x_rd_s2_r   <= 1'b0;
      x_byte_s2_r <= 1'b0;
      x_sel_s2_r  <= 1'b0;
      x_zero_s2_r <= 1'b0;
      y_rd_s1_r   <= 1'b0;
      y_zero_s1_r <= 1'b0;
      y_rd_s2_r   <= 1'b0;
      y_zero_s2_r <= 1'b0;
    end else begin
      x_rd_s1_r   <= acc_rd;
      x_byte_s1_r <= acc_byte;
      x_sel_s1_r  <= acc_ea[0];
      x_zero_s1_r <= zero_x;
      x_rd_s2_r   <= x_rd_s1_r;
      x_byte_s2_r <= x_byte_s1_r;
      x_sel_s2_r  <= x_sel_s1_r;
      x_zero_s2_r <= x_zero_s1_r;
      y_rd_s1_r   <= yreq_valid_in;
      y_zero_s1_r <= y_zero;
      y_rd_s2_r   <= y_rd_s1_r;
      y_zero_s2_r <= y_zero_s1_r;
    end
  end

  // byte select and zero substitution on the x read path
  always @* begin
    x_byte_nxt = x_sel_s2_r ? xmem_rdata_in[15:8] : xmem_rdata_in[7:0];
    if (x_zero_s2_r) begin
      x_byte_nxt = `DSAU_ZERO_BYTE;
    end
    if (x_zero_s2_r) begin
      x_word_nxt = `DSAU_ZERO_WORD;
    end else if (x_byte_s2_r) begin
      x_word_nxt = {8'h00, x_byte_nxt};
    end else begin
      x_word_nxt = xmem_rdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      x_rdata_out     <= 16'h0000;
      wreg_merged_out <= 16'h0000;
      x_rvalid_out    <= 1'b0;
    end else begin
      x_rvalid_out <= x_rd_s2_r;
      if (x_rd_s2_r) begin
        x_rdata_out     <= x_word_nxt;
        wreg_merged_out <= x_byte_s2_r ?
                           {wreg_old_in[15:8], x_byte_nxt} : x_word_nxt;
      end
    end
  end

  // y answers are always whole words
  always @(posedge mclk_in) begin
    if (rst_in) begin
      y_rdata_out  <= 16'h0000;
      y_rvalid_out <= 1'b0;
    end else begin
      y_rvalid_out <= y_rd_s2_r;
      if (y_rd_s2_r) begin
        y_rdata_out <= y_zero_s2_r ? `DSAU_ZERO_WORD : ymem_rdata_in;
      end
    end
  end

  // post-increment result, scaled by access size
  always @(posedge mclk_in) begin
    if (rst_in) begin
      ptr_next_out       <= 16'h0000;
      ptr_next_valid_out <= 1'b0;
    end else begin
      ptr_next_valid_out <= x_go & xreq_postinc_in;
      if (x_go & xreq_postinc_in) begin
        ptr_next_out <= xreq_ea_in +
                        (xreq_byte_in ? `DSAU_BYTE_STEP : `DSAU_WORD_STEP);
      end
    end
  end

  // trap requests, one cycle each, independent of one another
  always @(posedge mclk_in) begin
    if (rst_in) begin
      addr_err_trap_out  <= 1'b0;
      stack_err_trap_out <= 1'b0;
    end else begin
      // both traps may pulse together; the exception logic orders them
      addr_err_trap_out  <= misalign | y_misalign;
      stack_err_trap_out <= stk_err;
    end
  end

endmodule
`default_nettype wire

// ### dsau_top_monitor.sv
// port-level assertion checker for the data-space access unit
`timescale 1ns/10ps
`default_nettype none
module dsau_top_monitor #(
  parameter [15:0] Y_LO = 16'h0880,
  parameter [15:0] Y_HI = 16'h08ff
) (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_in,
  // requests
  input wire logic        xreq_valid_in,
  input wire logic        xreq_write_in,
  input wire logic        xreq_byte_in,
  input wire logic        xreq_near_in,
  input wire logic [15:0] xreq_ea_in,
  input wire logic        xreq_ready_out,
  input wire logic        yreq_valid_in,
  input wire logic [15:0] yreq_ea_in,
  input wire logic        stk_push_in,
  input wire logic        stk_pop_in,
  input wire logic        sp_wr_in,
  // answers
  input wire logic        x_rvalid_out,
  input wire logic [15:0] y_rdata_out,
  input wire logic        y_rvalid_out,
  input wire logic [15:0] stack_pointer_out,
  input wire logic        addr_err_trap_out,
  input wire logic        stack_err_trap_out,
  input wire logic        xmem_we_lo_out,
  input wire logic        xmem_we_hi_out
);
  wire xt = xreq_valid_in && xreq_ready_out;
  wire odd = xt && !xreq_byte_in && !xreq_near_in && xreq_ea_in[0];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_x_ans;
    xt && !xreq_write_in |-> ##3 x_rvalid_out;
  endproperty
  a_x_ans: assert property (p_x_ans) else $error("x read answer missing");
  property p_odd_trap;
    odd |-> ##1 addr_err_trap_out;
  endproperty
  a_odd_trap: assert property (p_odd_trap) else $error("no address trap");
  property p_odd_wr;
    odd && xreq_write_in |-> ##1 !(xmem_we_lo_out || xmem_we_hi_out);
  endproperty
  a_odd_wr: assert property (p_odd_wr) else $error("odd word write not held back");
  property p_lane;
    xt && xreq_write_in && xreq_byte_in |-> ##1 !(xmem_we_lo_out && xmem_we_hi_out);
  endproperty
  a_lane: assert property (p_lane) else $error("byte write hit both lanes");
  property p_y_zero;
    yreq_valid_in && (yreq_ea_in < Y_LO || yreq_ea_in > Y_HI)
      |-> ##3 y_rvalid_out && y_rdata_out == 16'h0000;
  endproperty
  a_y_zero: assert property (p_y_zero) else $error("y outside space not zero");
  property p_push;
    stk_push_in && !sp_wr_in
      |=> stack_pointer_out == $past(stack_pointer_out) + 16'h0002
          && xmem_we_lo_out && xmem_we_hi_out;
  endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_pop;
    stk_pop_in && !sp_wr_in |=> stack_pointer_out == $past(stack_pointer_out) - 16'h0002;
  endproperty
  a_pop: assert property (p_pop) else $error("pop step wrong");
  property p_strap;
    stack_err_trap_out |-> $past(stk_push_in || stk_pop_in);
  endproperty
  a_strap: assert property (p_strap) else $error("stack trap without cause");
  property p_busy;
    stk_push_in || stk_pop_in |-> !xreq_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("x bus offered during stack op");
  property p_pop_nowr;
    stk_pop_in |-> ##1 !(xmem_we_lo_out || xmem_we_hi_out);
  endproperty
  a_pop_nowr: assert property (p_pop_nowr) else $error("write strobe during pop");
  property p_y_odd;
    yreq_valid_in && yreq_ea_in[0] |-> ##1 addr_err_trap_out;
  endproperty
  a_y_odd: assert property (p_y_odd) else $error("no trap on odd y fetch");
endmodule
bind dsau_top dsau_top_monitor #(.Y_LO(Y_LO), .Y_HI(Y_HI)) i_dsau_top_monitor (.*);
`default_nettype wire

// ### dsau_mem_model.sv
// synchronous data memory: x port read-write, y port read only
`timescale 1ns/10ps
`default_nettype none
module dsau_mem_model (
  // clock
  input  wire logic        mclk_in,
  // x port
  input  wire logic [14:0] xaddr_in,
  input  wire logic        xrd_in,
  input  wire logic        xwe_lo_in,
  input  wire logic        xwe_hi_in,
  input  wire logic [15:0] xwdata_in,
  output var  logic [15:0] xrdata_out,
  // y port
  input  wire logic [14:0] yaddr_in,
  input  wire logic        yrd_in,
  output var  logic [15:0] yrdata_out
);
  logic [15:0] mem [0:32767];
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
  end
  // without a read the data lines invert, so a stale word never passes
  always @(posedge mclk_in) begin
    if (xwe_lo_in) mem[xaddr_in][7:0] <= xwdata_in[7:0];
    if (xwe_hi_in) mem[xaddr_in][15:8] <= xwdata_in[15:8];
    xrdata_out <= xrd_in ? mem[xaddr_in] : ~xrdata_out;
    yrdata_out <= yrd_in ? mem[yaddr_in] : ~yrdata_out;
  end
endmodule
`default_nettype wire

// ### data_space_access_unit_tb.sv
// self-checking bench for the data-space access unit
`timescale 1ns/10ps
`default_nettype none
module data_space_access_unit_tb;
  localparam logic [15:0] LO = 16'h0800, HI = 16'h08ff, YL = 16'h0880, YH = 16'h08ff;
  logic        mclk_in = 1'b0, rst_in = 1'b1;
  logic        xreq_valid_in, xreq_write_in, xreq_byte_in, xreq_mac_in, xreq_bitrev_in;
  logic        xreq_near_in, xreq_postinc_in, yreq_valid_in, stk_push_in, stk_pop_in;
  logic        sp_wr_in, limit_wr_in;
  logic [15:0] xreq_ea_in, xreq_wdata_in, wreg_old_in, yreq_ea_in, stk_push_data_in;
  logic [15:0] sp_wdata_in, limit_wdata_in;
  logic [12:0] xreq_near_addr_in;
  logic [1:0]  stk_push_src_in;
  logic [7:0]  status_low_byte_in;
  wire         xreq_ready_out, x_rvalid_out, ptr_next_valid_out, y_rvalid_out, ymem_rd_out;
  wire         addr_err_trap_out, stack_err_trap_out, xmem_rd_out, xmem_we_lo_out, xmem_we_hi_out;
  wire  [15:0] x_rdata_out, wreg_merged_out, ptr_next_out, y_rdata_out, stack_pointer_out;
  wire  [15:0] xmem_wdata_out, xmem_rdata_in, ymem_rdata_in;
  wire  [14:0] xmem_addr_out, ymem_addr_out;
  logic [15:0] sh [0:32767];
  logic [15:0] qd[$], qm[$], qy[$], qp[$];
  logic [15:0] sp = 16'h0800, lim;
  logic        lim_ld = 1'b0;
  int          miscompares = 0, check_count = 0;

  dsau_top #(.MEM_LO(LO), .MEM_HI(HI), .Y_LO(YL), .Y_HI(YH), .BR_BITS(8)) i_dsau_top (.*);
  dsau_mem_model i_dsau_mem_model (.mclk_in, .xaddr_in(xmem_addr_out), .xrd_in(xmem_rd_out),
    .xwe_lo_in(xmem_we_lo_out), .xwe_hi_in(xmem_we_hi_out), .xwdata_in(xmem_wdata_out),
    .xrdata_out(xmem_rdata_in), .yaddr_in(ymem_addr_out), .yrd_in(ymem_rd_out),
    .yrdata_out(ymem_rdata_in));

  always #5 mclk_in = ~mclk_in;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] rd(input logic [15:0] a);
    return (a >= LO && a <= HI) ? sh[a[15:1]] : 16'h0000;
  endfunction
  function automatic logic [7:0] rv(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rv[i] = x[7 - i];
  endfunction
  task automatic tick;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic idle;
    xreq_valid_in = 1'b0;
    yreq_valid_in = 1'b0;
    tick;
  endtask
  task automatic xa(input logic w, b, m, r, n, p, input logic [15:0] ea, d);
    logic [15:0] a, v;
    logic [7:0]  y;
    xreq_valid_in = 1'b1;
    {xreq_write_in, xreq_byte_in, xreq_mac_in, xreq_bitrev_in, xreq_near_in} = {w, b, m, r, n};
    xreq_postinc_in = p;
    xreq_near_addr_in = ea[12:0];
    xreq_ea_in = n ? 16'($urandom) : ea;
    xreq_wdata_in = d;
    if (p) qp.push_back(xreq_ea_in + (b ? 16'h0001 : 16'h0002));
    a = r ? {ea[15:9], rv(ea[8:1]), ea[0]} : ea;
    if (w && a >= LO && a <= HI && (b || !a[0])) begin
      if (!b) sh[a[15:1]] = d;
      else if (a[0]) sh[a[15:1]][15:8] = d[7:0];
      else sh[a[15:1]][7:0] = d[7:0];
    end
    v = (m && ea >= YL && ea <= YH) ? 16'h0000 : rd(ea);
    y = ea[0] ? v[15:8] : v[7:0];
    if (!w) qd.push_back(b ? {8'h00, y} : v);
    if (!w) qm.push_back(b ? {wreg_old_in[15:8], y} : v);
  endtask
  task automatic st(input logic u, input logic [1:0] s, input logic [15:0] d);
    logic [15:0] a;
    a = u ? sp : sp - 16'h0002;
    {stk_push_in, stk_pop_in, stk_push_src_in, stk_push_data_in} = {u, !u, s, d};
    // a competing x request must be dropped: no answer, no pointer, no strobe
    {xreq_valid_in, xreq_write_in, xreq_byte_in, xreq_postinc_in} = {1'b1, !u, 2'b01};
    xreq_ea_in = 16'h0860;
    if (u && a >= LO && a <= HI)
      sh[a[15:1]] = s == 2'h0 ? d : {s == 2'h2 ? status_low_byte_in : 8'h00, d[7:0]};
    if (!u) qd.push_back(rd(a));
    if (!u) qm.push_back(rd(a));
    sp = u ? sp + 16'h0002 : a;
    tick;
    {stk_push_in, stk_pop_in, xreq_valid_in} = 3'b000;
    chk({15'h0, stack_err_trap_out}, {15'h0, a < 16'h0800 || (lim_ld && a > lim)});
    chk(stack_pointer_out, sp);
    tick;
  endtask
  task automatic ld(input logic l, input logic [15:0] v);
    {limit_wr_in, sp_wr_in, sp_wdata_in, limit_wdata_in} = {l, !l, v, v};
    if (l) lim = v & 16'hfffe;
    else sp = v & 16'hfffe;
    lim_ld = lim_ld | l;
    tick;
    {limit_wr_in, sp_wr_in} = 2'b00;
    tick;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_in) begin
    #2;
    if (x_rvalid_out === 1'b1) begin
      chk(x_rdata_out, qd.pop_front());
      chk(wreg_merged_out, qm.pop_front());
    end
    if (y_rvalid_out === 1'b1) chk(y_rdata_out, qy.pop_front());
    if (ptr_next_valid_out === 1'b1) chk(ptr_next_out, qp.pop_front());
  end

  // the tests need well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end

  initial begin
    for (int i = 0; i < 32768; i++) sh[i] = 16'h0000;
    {xreq_valid_in, xreq_write_in, xreq_byte_in, xreq_mac_in, xreq_bitrev_in} = 5'h00;
    {xreq_near_in, xreq_postinc_in, yreq_valid_in, stk_push_in, stk_pop_in} = 5'h00;
    {sp_wr_in, limit_wr_in, stk_push_src_in, xreq_near_addr_in} = 17'h00000;
    {xreq_ea_in, xreq_wdata_in, yreq_ea_in, stk_push_data_in} = 64'h0;
    {sp_wdata_in, limit_wdata_in} = 32'h0;
    void'($urandom(63507));
    wreg_old_in = 16'($urandom);
    status_low_byte_in = 8'($urandom);
    repeat (5) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    chk(stack_pointer_out, 16'h0800);
    for (int i = 0; i < 300; i++) begin
      if (1'($urandom)) begin
        yreq_valid_in = 1'b1;
        yreq_ea_in = 16'h07f0 + 16'($urandom % 288);
        qy.push_back((yreq_ea_in >= YL && yreq_ea_in <= YH) ? rd(yreq_ea_in) : 16'h0000);
      end else yreq_valid_in = 1'b0;
      xa(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), $urandom % 4 == 0,
         1'($urandom), 16'h07f0 + 16'($urandom % 288), 16'($urandom));
      tick;
    end
    idle;
    $display("test random done");
    xa(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0900, 16'h5a3c);
    tick;
    xa(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0802, 16'h0000);
    tick;
    idle;
    $display("test bitrev done");
    ld(1'b0, 16'h0840);
    // first stack access after the limit load is a push, never a read
    ld(1'b1, 16'h0843);
    for (int i = 0; i < 3; i++) st(1'b1, 2'(i), 16'($urandom));
    repeat (3) st(1'b0, 2'h0, 16'h0000);
    ld(1'b0, 16'h0800);
    st(1'b0, 2'h0, 16'h0000);
    repeat (5) tick;
    $display("test stack done");
    end_of_test;
  end
endmodule
`default_nettype wire
